// ---- common/lcd_basic_defs.svh ----
`ifndef LCD_BASIC_DEFS_SVH
`define LCD_BASIC_DEFS_SVH

// Function-setting instruction layout
`define FSET_OPC_HI 7
`define FSET_OPC_LO 5
`define FSET_OPC 3'h1
`define FSET_ZERO_BIT 3
`define FSET_WIDTH_BIT 4
`define FSET_LINES_BIT 2
`define FSET_MUX_BIT 1
`define FSET_ISET_BIT 0
// Set-address instructions (standard group)
`define SET_DISP_BIT 7
`define SET_PAT_HI 7
`define SET_PAT_LO 6
`define SET_PAT_OPC 2'h1
// Control byte of the serial path
`define CTRL_CONT_BIT 7
`define CTRL_RS_BIT 6
// Reset values of the configuration bits
`define RST_WIDTH_PAR 1'h0
`define RST_WIDTH_SER 1'h1
`define RST_LINES 1'h0
`define RST_MUX 1'h0
`define RST_ISET 1'h0
// Busy time of one basic instruction in oscillator cycles
`define EXEC_CYCLES 4'h3
// Memory sizes
`define DISP_WORDS 128
`define PAT_WORDS 128
// Pattern memory keeps bits 4..0
`define PAT_DATA_MASK 8'h1F

`endif

// ---- common/lcd_basic_pkg.sv ----
package lcd_basic_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_STEP,
    OP_FETCH
  } exec_op_t;
  typedef enum logic {
    MEM_DISPLAY,
    MEM_PATTERN
  } mem_sel_t;
endpackage : lcd_basic_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : pin_sync

// ---- hdl/nibble_pack.sv ----
`timescale 1ns/1ps
// Joins two nibble transfers into one byte, upper nibble first
module nibble_pack (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic four_bit,
  input wire logic xfer,
  input wire logic [3:0] nib,
  input wire logic [7:0] full,
  input wire logic clear,
  output logic byte_done,
  output logic [7:0] byte_val,
  output logic second_half
);
  logic [3:0] hi_r;
  logic half_r;

  assign second_half = half_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
      hi_r <= 4'h0;
    end else if (clear || !four_bit) begin
      half_r <= 1'b0;
    end else if (xfer) begin
      half_r <= !half_r;
      if (!half_r) begin
        hi_r <= nib;
      end
    end
  end

  always_comb begin
    byte_done = xfer && (!four_bit || half_r);
    byte_val = four_bit ? {hi_r, nib} : full;
  end
endmodule : nibble_pack

// ---- hdl/lcd_basic_instruction_unit.sv ----
`timescale 1ns/1ps
`include "lcd_basic_defs.svh"
// How it works
// - Function set: RS0, write, 001x0xxx
// - Bit 4 picks four or eight bits
// - Four-bit bytes take two transfers
// - Bit 2 picks one or two lines while bit 1 is low
// - Bit 1 picks 1:18 or 1:9 mux
// - Bit 0 picks standard or extended set
// - Serial mode powers up eight-bit wide
// - Status read returns busy and counter
// - Busy high blocks new instructions
// - One counter, loaded by set-address
// - Data read uses last selected memory
// - Read drives register, then steps, prefetches
// - Only set-address and read load register
// - Data write stores, counter steps by one
// - Pattern writes keep bits four to zero
// - Instruction register cannot be read back
// - Serial bytes follow a control byte
module lcd_basic_instruction_unit
  import lcd_basic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // Parallel pins
  input wire logic serial_mode,
  input wire logic strobe,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic [7:0] db_oe,
  // Serial byte path from the bus slave (same clock)
  input wire logic ser_valid,
  input wire logic [7:0] ser_byte,
  input wire logic ser_first,
  output logic [7:0] ser_rd_data,
  // Direction from entry mode (1 = increment)
  input wire logic entry_increment,
  // Configuration and status
  output logic bus_width_bit,
  output logic two_line,
  output logic reduced_mux_bit,
  output logic extended_set,
  output logic busy_indicator,
  output logic [6:0] address_counter,
  output logic mem_is_pattern,
  output logic second_line_off
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic strobe_s, rs_s, rnw_s, ser_s;
  logic [7:0] db_s;
  logic strobe_d_r;

  pin_sync #(.W(12)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({strobe, register_select, read_not_write, serial_mode, db_in}),
    .q({strobe_s, rs_s, rnw_s, ser_s, db_s})
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_s;
    end
  end

  logic strobe_fall;
  assign strobe_fall = strobe_d_r && !strobe_s;

  // ==========================================================
  // Byte assembly
  // ==========================================================
  logic par_done, second_half;
  logic [7:0] par_byte;
  logic par_write, par_read_done;
  assign par_write = strobe_fall && !rnw_s && !ser_s;
  assign par_read_done = strobe_fall && rnw_s && !ser_s;

  nibble_pack u_pack (
    .sys_clk(sys_clk),
    .rst(rst),
    .four_bit(!bus_width_bit),
    .xfer(strobe_fall && !ser_s),
    .nib(db_s[7:4]),
    .full(db_s),
    .clear(ser_s),
    .byte_done(par_done),
    .byte_val(par_byte),
    .second_half(second_half)
  );

  // Serial: control byte carries RS for the following byte
  logic ser_rs_r, expect_ctrl_r, ser_byte_cont_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_rs_r <= 1'b0;
      expect_ctrl_r <= 1'b1;
    end else if (ser_valid && ser_first) begin
      expect_ctrl_r <= 1'b1;
    end else if (ser_valid && expect_ctrl_r) begin
      ser_rs_r <= ser_byte[`CTRL_RS_BIT];
      expect_ctrl_r <= 1'b0;
    end else if (ser_valid) begin
      expect_ctrl_r <= ser_byte_cont_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_byte_cont_r <= 1'b0;
    end else if (ser_valid && (expect_ctrl_r || ser_first)) begin
      ser_byte_cont_r <= ser_byte[`CTRL_CONT_BIT];
    end
  end

  logic ser_data;
  assign ser_data = ser_valid && !expect_ctrl_r && !ser_first;

  // One write command per cycle from either path
  logic wr_valid, wr_rs;
  logic [7:0] wr_byte;
  always_comb begin
    wr_valid = (par_write && par_done) || ser_data;
    wr_rs = ser_s ? ser_rs_r : rs_s;
    wr_byte = ser_s ? ser_byte : par_byte;
  end

  // ==========================================================
  // Busy tracking
  // ==========================================================
  logic [3:0] busy_cnt_r;
  assign busy_indicator = (busy_cnt_r != 4'h0);

  logic accept;
  assign accept = wr_valid && !busy_indicator;

  // ==========================================================
  // Decode
  // ==========================================================
  logic is_fset, is_set_disp, is_set_pat, is_data_wr;
  always_comb begin
    is_fset = accept && !wr_rs
      && (wr_byte[`FSET_OPC_HI:`FSET_OPC_LO] == `FSET_OPC)
      && !wr_byte[`FSET_ZERO_BIT];
    is_set_disp = accept && !wr_rs && !extended_set && wr_byte[`SET_DISP_BIT];
    is_set_pat = accept && !wr_rs && !extended_set
      && (wr_byte[`SET_PAT_HI:`SET_PAT_LO] == `SET_PAT_OPC);
    is_data_wr = accept && wr_rs;
  end

  // ==========================================================
  // Function set configuration
  // ==========================================================
  logic width_r, lines_r, mux_r, iset_r;
  logic strap_done_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      width_r <= `RST_WIDTH_PAR;
      lines_r <= `RST_LINES;
      mux_r <= `RST_MUX;
      iset_r <= `RST_ISET;
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (ser_s || (is_fset && strap_done_r)) begin
        width_r <= ser_s ? `RST_WIDTH_SER : wr_byte[`FSET_WIDTH_BIT];
      end
      if (is_fset && strap_done_r) begin
        lines_r <= wr_byte[`FSET_LINES_BIT];
        mux_r <= wr_byte[`FSET_MUX_BIT];
        iset_r <= wr_byte[`FSET_ISET_BIT];
      end
    end
  end

  always_comb begin
    bus_width_bit = width_r;
    two_line = lines_r && !mux_r;
    reduced_mux_bit = mux_r;
    second_line_off = mux_r;
    extended_set = iset_r;
  end

  // ==========================================================
  // Memories, counter and data register
  // ==========================================================
  logic [7:0] disp_mem [`DISP_WORDS];
  logic [7:0] pat_mem [`PAT_WORDS];
  logic [6:0] ac_r;
  logic [7:0] data_r;
  mem_sel_t sel_r;
  exec_op_t op_r;
  logic [6:0] ac_step;

  assign address_counter = ac_r;
  assign mem_is_pattern = (sel_r == MEM_PATTERN);
  assign ac_step = entry_increment ? ac_r + 7'h01 : ac_r - 7'h01;

  logic rd_data_done;
  assign rd_data_done = par_read_done && rs_s && (bus_width_bit || second_half);

  always_ff @(posedge sys_clk) begin
    if (is_data_wr && sel_r == MEM_DISPLAY) begin
      disp_mem[ac_r] <= wr_byte;
    end
    if (is_data_wr && sel_r == MEM_PATTERN) begin
      pat_mem[ac_r] <= wr_byte & `PAT_DATA_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ac_r <= 7'h00;
      sel_r <= MEM_DISPLAY;
      op_r <= OP_NONE;
    end else if (is_set_disp) begin
      ac_r <= wr_byte[6:0];
      sel_r <= MEM_DISPLAY;
      op_r <= OP_FETCH;
    end else if (is_set_pat) begin
      ac_r <= {1'b0, wr_byte[5:0]};
      sel_r <= MEM_PATTERN;
      op_r <= OP_FETCH;
    end else if (is_data_wr) begin
      ac_r <= ac_step;
      op_r <= OP_NONE;
    end else if (rd_data_done && !busy_indicator) begin
      ac_r <= ac_step;
      op_r <= OP_FETCH;
    end else begin
      op_r <= OP_NONE;
    end
  end

  // Data register only reloads on a fetch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_r <= 8'h00;
    end else if (op_r == OP_FETCH) begin
      data_r <= (sel_r == MEM_PATTERN) ? pat_mem[ac_r] : disp_mem[ac_r];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 4'h0;
    end else if (accept || (rd_data_done && !busy_indicator)) begin
      busy_cnt_r <= `EXEC_CYCLES;
    end else if (busy_cnt_r != 4'h0) begin
      busy_cnt_r <= busy_cnt_r - 4'h1;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = rs_s ? data_r : {busy_indicator, ac_r};
    ser_rd_data = ser_rs_r ? data_r : {busy_indicator, ac_r};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      db_out <= 8'h00;
      db_oe <= 8'h00;
    end else if (strobe_s && rnw_s && !ser_s) begin
      db_out <= (!bus_width_bit && second_half) ? {rd_byte[3:0], 4'h0} : rd_byte;
      db_oe <= bus_width_bit ? 8'hFF : 8'hF0;
    end else begin
      db_oe <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_busy_blocks;
    @(posedge sys_clk) disable iff (rst)
    (busy_indicator && wr_valid && !wr_rs) |=> $stable(width_r) && $stable(iset_r);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("config changed while busy");

  property p_busy_len;
    @(posedge sys_clk) disable iff (rst)
    accept |=> busy_indicator [*3] ##1 !busy_indicator;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_fset_iset;
    @(posedge sys_clk) disable iff (rst)
    (is_fset && strap_done_r) |=> extended_set == $past(wr_byte[0]);
  endproperty
  a_fset_iset: assert property (p_fset_iset) else $error("set select not taken");

  property p_fset_mux;
    @(posedge sys_clk) disable iff (rst)
    (is_fset && strap_done_r) |=> reduced_mux_bit == $past(wr_byte[1]);
  endproperty
  a_fset_mux: assert property (p_fset_mux) else $error("mux bit not taken");

  property p_sl_one_line;
    @(posedge sys_clk) disable iff (rst)
    reduced_mux_bit |-> !two_line;
  endproperty
  a_sl_one_line: assert property (p_sl_one_line) else $error("two lines under 1:9");

  property p_wr_step;
    @(posedge sys_clk) disable iff (rst)
    (is_data_wr && entry_increment) |=> address_counter == $past(ac_r) + 7'h01;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("counter not stepped");

  property p_setdisp_load;
    @(posedge sys_clk) disable iff (rst)
    is_set_disp |=> address_counter == $past(wr_byte[6:0]) && !mem_is_pattern;
  endproperty
  a_setdisp_load: assert property (p_setdisp_load) else $error("counter not loaded");

  property p_data_hold;
    @(posedge sys_clk) disable iff (rst)
    is_data_wr |=> ##1 $stable(data_r);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write changed data register");

  c_fset: cover property (@(posedge sys_clk) disable iff (rst) is_fset);
  c_wr: cover property (@(posedge sys_clk) disable iff (rst) is_data_wr);
  c_rd: cover property (@(posedge sys_clk) disable iff (rst) rd_data_done);
endmodule : lcd_basic_instruction_unit

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] db_out,
  output logic strobe,
  output logic register_select,
  output logic read_not_write,
  output logic [7:0] db_in,
  output logic ser_valid,
  output logic [7:0] ser_byte,
  output logic ser_first
);
  // ==========================================
  // Idle levels, released lines at pull-up
  initial begin
    strobe = 1'b0;
    register_select = 1'b0;
    read_not_write = 1'b0;
    db_in = 8'hFF;
    ser_valid = 1'b0;
    ser_byte = 8'hFF;
    ser_first = 1'b0;
  end

  // ==========================================
  // One strobe cycle on the parallel pins
  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d,
                      output logic [7:0] rd);
    @(posedge sys_clk);
    #1;
    register_select = rs;
    read_not_write = rnw;
    db_in = rnw ? 8'hFF : d;
    strobe = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rd = db_out;
    strobe = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    db_in = 8'hFF;
  endtask : xfer

  // Byte transfer; four-bit mode sends upper nibble first, low lines open
  task automatic par_byte(input logic rs, input logic rnw, input logic [7:0] d,
                          input logic four, output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four) begin
      xfer(rs, rnw, {d[7:4], 4'hF}, hi);
      xfer(rs, rnw, {d[3:0], 4'hF}, lo);
      rd = {hi[7:4], lo[7:4]};
    end else begin
      xfer(rs, rnw, d, rd);
    end
  endtask : par_byte

  // ==========================================
  // One byte on the serial path
  task automatic ser_send(input logic f, input logic [7:0] b);
    @(posedge sys_clk);
    #1;
    ser_valid = 1'b1;
    ser_first = f;
    ser_byte = b;
    @(posedge sys_clk);
    #1;
    ser_valid = 1'b0;
    ser_first = 1'b0;
    ser_byte = ~b;
  endtask : ser_send
endmodule : host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import lcd_basic_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic serial_mode = 1'b0;
  logic entry_increment = 1'b1;
  logic strobe, register_select, read_not_write, ser_valid, ser_first;
  logic [7:0] db_in, db_out, db_oe, ser_byte, ser_rd_data, v;
  logic bus_width_bit, two_line, reduced_mux_bit, extended_set, busy_indicator;
  logic mem_is_pattern, second_line_off;
  logic [6:0] address_counter;
  logic four = 1'b1;
  int err_count = 0;
  int n_compared = 0;

  always #2 sys_clk = ~sys_clk;

  lcd_basic_instruction_unit dut_u (.sys_clk(sys_clk), .rst(rst), .serial_mode(serial_mode),
    .strobe(strobe), .register_select(register_select), .read_not_write(read_not_write),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .ser_valid(ser_valid),
    .ser_byte(ser_byte), .ser_first(ser_first), .ser_rd_data(ser_rd_data),
    .entry_increment(entry_increment), .bus_width_bit(bus_width_bit), .two_line(two_line),
    .reduced_mux_bit(reduced_mux_bit), .extended_set(extended_set),
    .busy_indicator(busy_indicator), .address_counter(address_counter),
    .mem_is_pattern(mem_is_pattern), .second_line_off(second_line_off));

  host_model host_u (.sys_clk(sys_clk), .db_out(db_out), .strobe(strobe),
    .register_select(register_select), .read_not_write(read_not_write), .db_in(db_in),
    .ser_valid(ser_valid), .ser_byte(ser_byte), .ser_first(ser_first));

  // ==========================================
  // Helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic do_reset(input logic ser);
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    serial_mode = ser;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : do_reset

  task automatic wr(input logic rs, input logic [7:0] d);
    host_u.par_byte(rs, 1'b0, d, four, v);
  endtask : wr

  task automatic rd(input logic rs);
    host_u.par_byte(rs, 1'b1, 8'h00, four, v);
  endtask : rd

  // ==========================================
  // Scenarios
  task automatic t_fset();
    host_u.xfer(1'b0, 1'b0, 8'h2F, v);
    chk("mux after half", reduced_mux_bit, 8'h00);
    host_u.xfer(1'b0, 1'b0, 8'h6F, v);
    chk("width", bus_width_bit, 8'h00);
    chk("mux", reduced_mux_bit, 8'h01);
    chk("line off", second_line_off, 8'h01);
    wr(1'b0, 8'h34);
    four = 1'b0;
    chk("width", bus_width_bit, 8'h01);
    chk("lines", two_line, 8'h01);
    chk("mux", reduced_mux_bit, 8'h00);
    wr(1'b0, 8'h31);
    chk("ext", extended_set, 8'h01);
    chk("lines", two_line, 8'h00);
    wr(1'b0, 8'h30);
    wr(1'b0, 8'h3D);
    chk("ext bit3", extended_set, 8'h00);
    chk("mux bit3", reduced_mux_bit, 8'h00);
    $display("test fset done");
  endtask : t_fset

  task automatic t_write();
    wr(1'b0, 8'h85);
    chk("ac", address_counter, 8'h05);
    chk("pattern", mem_is_pattern, 8'h00);
    rd(1'b0);
    chk("status", v, 8'h05);
    wr(1'b1, 8'hA5);
    chk("ac inc", address_counter, 8'h06);
    entry_increment = 1'b0;
    wr(1'b1, 8'h3C);
    chk("ac dec", address_counter, 8'h05);
    entry_increment = 1'b1;
    wr(1'b0, 8'hFF);
    wr(1'b1, 8'h11);
    chk("ac wrap", address_counter, 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    wr(1'b0, 8'h85);
    wr(1'b1, 8'h77);
    fork
      rd(1'b1);
      begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk("read drive", db_oe, 8'hFF);
      end
    join
    chk("data reg kept", v, 8'hA5);
    chk("ac read", address_counter, 8'h07);
    wr(1'b0, 8'h85);
    rd(1'b1);
    chk("read", v, 8'h77);
    rd(1'b1);
    chk("prefetch", v, 8'h3C);
    wr(1'b0, 8'h42);
    chk("pattern sel", mem_is_pattern, 8'h01);
    chk("pattern ac", address_counter, 8'h02);
    wr(1'b1, 8'hFF);
    wr(1'b0, 8'h42);
    rd(1'b1);
    chk("pattern data", v, 8'h1F);
    $display("test read done");
  endtask : t_read

  task automatic t_serial();
    do_reset(1'b1);
    chk("ser width", bus_width_bit, 8'h01);
    host_u.ser_send(1'b1, 8'h00);
    host_u.ser_send(1'b0, 8'h80);
    host_u.ser_send(1'b0, 8'h85);
    host_u.ser_send(1'b0, 8'h40);
    host_u.ser_send(1'b0, 8'h5A);
    repeat (10) @(posedge sys_clk);
    chk("ser ac", address_counter, 8'h06);
    host_u.ser_send(1'b1, 8'h00);
    host_u.ser_send(1'b0, 8'h00);
    host_u.ser_send(1'b0, 8'h90);
    chk("busy", busy_indicator, 8'h01);
    host_u.ser_send(1'b0, 8'hA0);
    repeat (10) @(posedge sys_clk);
    chk("busy drop", address_counter, 8'h10);
    chk("ser status", ser_rd_data, 8'h10);
    $display("test serial done");
  endtask : t_serial

  // ==========================================
  // Main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_fset();
    t_write();
    t_read();
    t_serial();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
endmodule : tb_top
